// File: verilog/sip_top.sv
// Overview of operation
// R1: Each enabled interrupt event drives interrupt_out_n low for one pulse.
// R2: Output behaviour and pulse length are set only during initialisation.
// R3: Masked sources never produce a pulse.
// R4: Level change on io0, io2..io5 each raises its own event.
// R5: Wake-up of io0, io2..io5 each raises its own separate event.
// R6: Clock count other than sixteen in a frame flags an error when active.
// R7: Bad read/write, unknown address, init-register write in normal mode flag.
// R8: Frame parity failure while main machine active flags an error.
// R9: Host may request an interrupt pulse at any time.
// R10: Long-duration timer reaching after-run value raises an event.
// R11: CAN clamps, overtemperature and wake each raise separate events.
// R12: LIN clamps, overtemperature and wake each raise separate events.
// R13: Regulator current limits raise events; timeouts only with external transistor.
// R14: Battery sense and low supply undervoltage each raise an event.
// R15: CAN supply shuts down when hot, restarts after hysteresis cooling.
// R16: Pre-regulator mode, activation, overvoltage and undervoltage are reported.
// R17: Secured-frame check failure raises an error event.
// R18: Flags hold until read; new pulse only on a further unmasked event.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sip_consts.svh"

module sip_top
  import sip_pkg::*;
#(
  parameter int TICK_CYC = `SIP_TICK_CYC
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // High until access is answered
  output logic irq, // Level interrupt to software
  output logic interrupt_out_n, // Active-low interrupt pulse
  output logic can_supply_en, // CAN supply pass transistor enable
  input wire logic init_phase, // Device in initialisation phase
  input wire logic normal_mode, // Device in normal mode
  input wire logic main_active, // Main state machine active
  input wire logic chip_select_n, // Serial chip select, active low
  input wire logic spi_sclk, // Serial clock level
  input wire sip_spi_frame_t spi_frame, // Decoded frame result
  input wire logic battery_sense_undervoltage, // Battery sense below threshold
  input wire logic supply_undervoltage_low, // Supply after diode below threshold
  input wire logic sensor_supply_limit, // Sensor regulator in current limit
  input wire logic sensor_supply_limit_timeout, // Sensor limit duration expired
  input wire logic aux_supply_limit, // Aux regulator in current limit
  input wire logic aux_supply_limit_timeout, // Aux limit duration expired
  input wire logic ext_pass_transistor, // External pass transistor fitted
  input wire logic can_tsd_hot, // CAN supply junction above shutdown
  input wire logic can_tsd_cool, // Below shutdown minus hysteresis
  input wire sip_prereg_t prereg, // Pre-regulator live state
  input wire logic [4:0] io_level, // io0, io2, io3, io4, io5 levels
  input wire logic [4:0] io_wake, // io0_wake_event and io2..io5 wake
  input wire sip_xcvr_t can_flags, // CAN transceiver flags
  input wire sip_xcvr_t lin_flags, // LIN transceiver flags
  input wire logic long_timer_func1_done // Long timer after-run reached
);
  sip_state_t s_q, s_d;

  logic [`SIP_NUM_EV-1:0] set_ev;
  logic [4:0] io_chg;
  logic [23:0] rise_ev;
  logic pulse_trig;
  logic pulse_busy;
  logic ack;
  logic wr_now;
  logic rd_now;
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  logic err_clk;
  logic err_req;
  logic err_par;
  logic err_sec;
  logic tsd_ev;
  logic int_req;
  logic [31:0] ctrl_w;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic sel(input logic [4:0] addr, input logic [4:0] off);
    return addr == off;
  endfunction

  sip_edge #(
    .W(5),
    .ANY(1'b1)
  ) u_io_edge (
    .clk(clk),
    .rst_n(rst_n),
    .lvl(io_level),
    .ev(io_chg)
  );

  // Level flags count once on assertion; a held fault does not refire
  sip_edge #(
    .W(24),
    .ANY(1'b0)
  ) u_rise_edge (
    .clk(clk),
    .rst_n(rst_n),
    .lvl({long_timer_func1_done, lin_flags, can_flags, io_wake,
          prereg.undervoltage, prereg.overvoltage,
          aux_supply_limit_timeout & ext_pass_transistor, aux_supply_limit,
          sensor_supply_limit_timeout & ext_pass_transistor, sensor_supply_limit,
          supply_undervoltage_low, battery_sense_undervoltage}),
    .ev(rise_ev)
  );

  sip_pulse #(
    .TICK_CYC(TICK_CYC)
  ) u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .trig(pulse_trig),
    .width(s_q.pwidth),
    .out_n(interrupt_out_n),
    .busy(pulse_busy)
  );

  assign ack = s_q.waitreq && (avs_read || avs_write);
  assign wr_now = !s_q.waitreq && avs_write;
  assign rd_now = !s_q.waitreq && avs_read;

  assign sclk_rise = spi_sclk && !s_q.sclk_prev;
  assign cs_rise = chip_select_n && !s_q.cs_prev;
  assign cs_fall = !chip_select_n && s_q.cs_prev;

  always_comb begin
    err_clk = cs_rise && main_active && (s_q.sclk_cnt != `SIP_SPI_BITS); // see R6
    err_par = spi_frame.done && spi_frame.parity_fail && main_active; // see R8
    err_req = spi_frame.done && (spi_frame.bad_rw || spi_frame.bad_addr ||
              (spi_frame.is_write && spi_frame.init_reg && normal_mode)); // see R7
    err_sec = spi_frame.done && spi_frame.secure_fail; // see R17
    tsd_ev = s_q.can_en && can_tsd_hot; // see R15
    int_req = wr_now && sel(avs_address, `SIP_OFF_CTRL) && avs_byteenable[1] &&
              avs_writedata[`SIP_CTRL_REQ_BIT]; // see R9
  end

  always_comb begin
    set_ev = '0;
    set_ev[5:0] = rise_ev[5:0]; // see R13 see R14
    set_ev[6] = tsd_ev;
    set_ev[8:7] = rise_ev[7:6]; // see R16
    set_ev[13:9] = io_chg; // see R4
    set_ev[18:14] = rise_ev[12:8]; // see R5
    set_ev[23:19] = rise_ev[17:13]; // see R11
    set_ev[28:24] = rise_ev[22:18]; // see R12
    set_ev[29] = int_req;
    set_ev[30] = rise_ev[23]; // see R10
    set_ev[31] = err_sec;
    set_ev[32] = err_clk;
    set_ev[33] = err_req;
    set_ev[34] = err_par;
  end

  // Behaviour bit gates pulses, masked sources never start one
  assign pulse_trig = s_q.out_en && |(set_ev & s_q.mask); // see R1 see R3 see R18

  always_comb begin
    ctrl_w = '0;
    ctrl_w[`SIP_CTRL_EN_BIT] = s_q.out_en;
    ctrl_w[`SIP_CTRL_W_MSB:`SIP_CTRL_W_LSB] = s_q.pwidth;
  end

  always_comb begin
    logic [31:0] nctrl;
    logic [31:0] nmask_lo;
    logic [31:0] nmask_hi;
    logic [`SIP_NUM_EV-1:0] clr;
    nctrl = be_merge(ctrl_w, avs_writedata, avs_byteenable);
    nmask_lo = be_merge(s_q.mask[31:0], avs_writedata, avs_byteenable);
    nmask_hi = be_merge({29'h0, s_q.mask[`SIP_NUM_EV-1:32]}, avs_writedata,
                        avs_byteenable);
    clr = '0;
    s_d = s_q;

    s_d.sclk_prev = spi_sclk;
    s_d.cs_prev = chip_select_n;
    if (cs_fall) begin
      s_d.sclk_cnt = '0;
    end else if (!chip_select_n && sclk_rise && s_q.sclk_cnt != `SIP_SPI_SAT) begin
      s_d.sclk_cnt = s_q.sclk_cnt + 5'h01; // see R6
    end

    // Thermal shutdown wins over restart when both report at once
    if (can_tsd_hot) begin
      s_d.can_en = 1'b0; // see R15
    end else if (!s_q.can_en && can_tsd_cool) begin
      s_d.can_en = 1'b1; // see R15
    end

    if (ack) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = '0;
      if (avs_read) begin
        unique case (avs_address)
          `SIP_OFF_STAT_LO: s_d.rdata = s_q.stat[31:0];
          `SIP_OFF_STAT_HI: s_d.rdata = {29'h0, s_q.stat[`SIP_NUM_EV-1:32]};
          `SIP_OFF_MASK_LO: s_d.rdata = s_q.mask[31:0];
          `SIP_OFF_MASK_HI: s_d.rdata = {29'h0, s_q.mask[`SIP_NUM_EV-1:32]};
          `SIP_OFF_CTRL: s_d.rdata = ctrl_w;
          `SIP_OFF_STATE: begin
            s_d.rdata[`SIP_ST_BOB_BIT] = prereg.prereg_buck_boost_state; // see R16
            s_d.rdata[`SIP_ST_PREACT_BIT] = prereg.active;
            s_d.rdata[`SIP_ST_PREOV_BIT] = prereg.overvoltage;
            s_d.rdata[`SIP_ST_PREUV_BIT] = prereg.undervoltage;
            s_d.rdata[`SIP_ST_CANEN_BIT] = s_q.can_en;
            s_d.rdata[`SIP_ST_TSD_BIT] = can_tsd_hot;
            s_d.rdata[`SIP_ST_PULSE_BIT] = pulse_busy;
            s_d.rdata[`SIP_ST_IO_MSB:`SIP_ST_IO_LSB] = io_level;
          end
          default: s_d.rdata = '0;
        endcase
      end
    end else if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
    end

    if (rd_now && sel(avs_address, `SIP_OFF_STAT_LO)) begin
      clr[31:0] = '1; // see R18
    end
    if (rd_now && sel(avs_address, `SIP_OFF_STAT_HI)) begin
      clr[`SIP_NUM_EV-1:32] = '1; // see R18
    end
    if (wr_now && sel(avs_address, `SIP_OFF_MASK_LO)) begin
      s_d.mask[31:0] = nmask_lo; // see R3
    end
    if (wr_now && sel(avs_address, `SIP_OFF_MASK_HI)) begin
      s_d.mask[`SIP_NUM_EV-1:32] = nmask_hi[`SIP_HI_EV-1:0]; // see R3
    end
    // Configuration is frozen outside initialisation; only the request acts
    if (wr_now && sel(avs_address, `SIP_OFF_CTRL) && init_phase) begin
      s_d.out_en = nctrl[`SIP_CTRL_EN_BIT]; // see R2
      s_d.pwidth = nctrl[`SIP_CTRL_W_MSB:`SIP_CTRL_W_LSB]; // see R2
    end

    // Fresh events survive a read-clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | set_ev; // see R18
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign irq = s_q.irq;
  assign can_supply_en = s_q.can_en;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mask <= `SIP_RST_MASK;
      s_q.out_en <= `SIP_RST_EN;
      s_q.pwidth <= `SIP_RST_WIDTH;
      s_q.can_en <= 1'b1;
      s_q.cs_prev <= 1'b1;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // sip_top

`default_nettype wire

// File: include/sip_consts.svh
`ifndef SIP_CONSTS_SVH
`define SIP_CONSTS_SVH

`define SIP_NUM_EV 35
`define SIP_HI_EV 3

`define SIP_OFF_STAT_LO 5'h00
`define SIP_OFF_STAT_HI 5'h04
`define SIP_OFF_MASK_LO 5'h08
`define SIP_OFF_MASK_HI 5'h0C
`define SIP_OFF_CTRL 5'h10
`define SIP_OFF_STATE 5'h14

`define SIP_CTRL_EN_BIT 0
`define SIP_CTRL_W_LSB 4
`define SIP_CTRL_W_MSB 7
`define SIP_CTRL_REQ_BIT 8
`define SIP_RST_EN 1'b1
`define SIP_RST_WIDTH 4'h3
`define SIP_RST_MASK 35'h7_FFFF_FFFF

`define SIP_ST_BOB_BIT 0
`define SIP_ST_PREACT_BIT 1
`define SIP_ST_PREOV_BIT 2
`define SIP_ST_PREUV_BIT 3
`define SIP_ST_CANEN_BIT 4
`define SIP_ST_TSD_BIT 5
`define SIP_ST_PULSE_BIT 6
`define SIP_ST_IO_LSB 8
`define SIP_ST_IO_MSB 12

`define SIP_SPI_BITS 5'h10
`define SIP_SPI_SAT 5'h1F

`define SIP_CLK_NS 25
`define SIP_TICK_NS 1000
`define SIP_TICK_CYC ((`SIP_TICK_NS + `SIP_CLK_NS - 1) / `SIP_CLK_NS)

`endif

// File: include/sip_pkg.sv
`include "sip_consts.svh"

package sip_pkg;

  typedef struct packed {
    logic done;
    logic is_write;
    logic bad_rw;
    logic bad_addr;
    logic init_reg;
    logic parity_fail;
    logic secure_fail;
  } sip_spi_frame_t;

  typedef struct packed {
    logic rx_recessive_clamp;
    logic tx_dominant_clamp;
    logic bus_dominant_clamp;
    logic overtemp;
    logic wake_event;
  } sip_xcvr_t;

  typedef struct packed {
    logic prereg_buck_boost_state;
    logic active;
    logic overvoltage;
    logic undervoltage;
  } sip_prereg_t;

  typedef struct packed {
    logic [`SIP_NUM_EV-1:0] stat;
    logic [`SIP_NUM_EV-1:0] mask;
    logic out_en;
    logic [3:0] pwidth;
    logic can_en;
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] sclk_cnt;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
  } sip_state_t;

endpackage

// File: verilog/sip_edge.sv
`timescale 1ns/1ps
`default_nettype none

module sip_edge #(
  parameter int W = 5,
  parameter bit ANY = 1'b0
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [W-1:0] lvl, // Sampled levels
  output logic [W-1:0] ev // One-cycle event per bit
);
  typedef struct packed {
    logic primed;
    logic [W-1:0] prev;
  } sip_edge_st_t;

  sip_edge_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.primed = 1'b1;
    s_d.prev = lvl;
  end

  // First cycle after reset only learns the levels, so no false change
  assign ev = !s_q.primed ? '0 : (ANY ? (lvl ^ s_q.prev) : (lvl & ~s_q.prev));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // sip_edge

`default_nettype wire

// File: verilog/sip_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "sip_consts.svh"

module sip_pulse #(
  parameter int TICK_CYC = `SIP_TICK_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic trig, // Start or restart a pulse
  input wire logic [3:0] width, // Pulse length minus one, in ticks
  output logic out_n, // Active-low pulse, registered
  output logic busy // Pulse in progress
);
  typedef struct packed {
    logic [15:0] div;
    logic [4:0] rem;
    logic out_n;
  } sip_pulse_st_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  sip_pulse_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (trig) begin
      // Retrigger restarts the full length; overlapping events merge
      s_d.rem = 5'(width) + 5'h01;
      s_d.div = '0;
    end else if (s_q.rem != '0) begin
      if (s_q.div == TICK_LAST) begin
        s_d.div = '0;
        s_d.rem = s_q.rem - 5'h01;
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end
    s_d.out_n = (s_d.rem == '0);
  end

  assign out_n = s_q.out_n;
  assign busy = (s_q.rem != '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.out_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // sip_pulse

`default_nettype wire

// File: verif/sip_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sip_top_assertions
  import sip_pkg::*;
#(
  parameter int TICK_CYC = 40
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic avs_waitrequest, // Bus stall
  input wire logic irq, // Level interrupt
  input wire logic interrupt_out_n, // Interrupt pulse
  input wire logic can_supply_en, // CAN supply enable
  input wire logic can_tsd_hot, // Above shutdown
  input wire logic can_tsd_cool // Cooled past hysteresis
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] low_q;
  always_ff @(posedge clk) begin
    low_q <= (!rst_n || interrupt_out_n) ? 8'h00 : low_q + 8'h01;
  end

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus request not answered in time");
  a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
    interrupt_out_n && avs_waitrequest && !irq && can_supply_en)
    else $error("outputs not idle after reset");
  a_tsd_off: assert property (can_tsd_hot |=> !can_supply_en)
    else $error("supply stays on while hot");
  a_tsd_back: assert property (can_tsd_cool && !can_tsd_hot |=> can_supply_en)
    else $error("supply not restarted after cooling");
  a_host_pulse: assert property (avs_write && !avs_waitrequest && avs_address == 5'h10
    && avs_writedata[8] |-> ##[1:3] !interrupt_out_n)
    else $error("host request gave no pulse");
  a_irq_pulse: assert property ($rose(irq) |-> !interrupt_out_n)
    else $error("unmasked event without pulse");
  a_pulse_irq: assert property ($fell(interrupt_out_n) |-> irq)
    else $error("pulse without unmasked event");
  a_pulse_len: assert property ($rose(interrupt_out_n) |-> low_q >= 8'(TICK_CYC))
    else $error("pulse shorter than one tick");
endmodule // sip_top_assertions

bind sip_top sip_top_assertions #(.TICK_CYC(TICK_CYC)) u_sip_top_assertions (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .interrupt_out_n(interrupt_out_n), .can_supply_en(can_supply_en),
  .can_tsd_hot(can_tsd_hot), .can_tsd_cool(can_tsd_cool));

`default_nettype wire

// File: verif/sip_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sip_host_model (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic start, // Begin a frame
  input wire logic [4:0] nclk, // Clock pulses in frame
  input wire logic interrupt_out_n, // Device pulse
  output logic chip_select_n, // Frame select
  output logic spi_sclk, // Serial clock
  output logic [7:0] pulses, // Pulses seen
  output logic [7:0] plen // Length of last pulse
);
  logic [5:0] ph_q;
  logic [7:0] low_q;
  logic int_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_q <= 6'h00;
      chip_select_n <= 1'b1;
      spi_sclk <= 1'b0;
      pulses <= 8'h00;
      plen <= 8'h00;
      low_q <= 8'h00;
      int_q <= 1'b1;
    end else begin
      int_q <= interrupt_out_n;
      low_q <= interrupt_out_n ? 8'h00 : low_q + 8'h01;
      // Clock stands low outside frames, as a real host leaves it
      if (start) begin
        ph_q <= {nclk, 1'b1};
        chip_select_n <= 1'b0;
      end else if (ph_q > 6'h01) begin
        ph_q <= ph_q - 6'h01;
        spi_sclk <= !spi_sclk;
      end else if (ph_q == 6'h01) begin
        ph_q <= 6'h00;
        chip_select_n <= 1'b1;
      end
      if (int_q && !interrupt_out_n) begin
        pulses <= pulses + 8'h01;
      end
      if (!int_q && interrupt_out_n) begin
        plen <= low_q;
      end
    end
  end
endmodule // sip_host_model

`default_nettype wire

// File: verif/tb_sbc_interrupt_pulse_generator.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sbc_interrupt_pulse_generator;
  import sip_pkg::*;
  localparam int TICK = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, interrupt_out_n, can_supply_en, chip_select_n, spi_sclk;
  logic init_phase = 1'b1;
  logic normal_mode = 1'b0;
  logic main_active = 1'b0;
  logic ext_pass = 1'b1;
  logic bb = 1'b0;
  logic act = 1'b0;
  logic [30:0] lv = '0;
  sip_spi_frame_t frame = '0;
  logic start = 1'b0;
  logic [4:0] nclk = 5'h10;
  logic [7:0] pulses, plen;
  logic [31:0] rst_exp [7] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'h7, 32'h31, 32'h10, 32'h0};
  int miscompares = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  sip_top #(.TICK_CYC(TICK)) u_sip_top (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .interrupt_out_n(interrupt_out_n), .can_supply_en(can_supply_en),
    .init_phase(init_phase), .normal_mode(normal_mode), .main_active(main_active),
    .chip_select_n(chip_select_n), .spi_sclk(spi_sclk), .spi_frame(frame),
    .battery_sense_undervoltage(lv[0]), .supply_undervoltage_low(lv[1]),
    .sensor_supply_limit(lv[2]), .sensor_supply_limit_timeout(lv[3]),
    .aux_supply_limit(lv[4]), .aux_supply_limit_timeout(lv[5]),
    .ext_pass_transistor(ext_pass), .can_tsd_hot(lv[6]), .can_tsd_cool(!lv[6]),
    .prereg({bb, act, lv[7], lv[8]}), .io_level(lv[13:9]), .io_wake(lv[18:14]),
    .can_flags(sip_xcvr_t'(lv[23:19])),
    .lin_flags(sip_xcvr_t'(lv[28:24])), .long_timer_func1_done(lv[30]));

  sip_host_model u_sip_host_model (
    .clk(clk), .rst_n(rst_n), .start(start), .nclk(nclk),
    .interrupt_out_n(interrupt_out_n), .chip_select_n(chip_select_n),
    .spi_sclk(spi_sclk), .pulses(pulses), .plen(plen));

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One full Avalon cycle; an edge passes after release so calls never collide
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        miscompares++;
        final_report();
      end
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [34:0] frame_exp(sip_spi_frame_t f, logic nm, logic ma);
    frame_exp = '0;
    frame_exp[31] = f.secure_fail;
    frame_exp[33] = f.bad_rw | f.bad_addr | (f.is_write & f.init_reg & nm);
    frame_exp[34] = f.parity_fail & ma;
  endfunction

  initial begin
    logic [34:0] m, e;
    logic [31:0] lo, hi;
    logic [7:0] p0;
    sip_spi_frame_t f;
    int k, n;
    void'($urandom(74));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0, lo);
      chk("reset read", {3'b0, rst_exp[i]}, {3'b0, lo});
    end
    bus(1'b1, 5'h10, 32'h11, lo);
    init_phase <= 1'b0;
    bus(1'b1, 5'h10, 32'hF0, lo);
    bus(1'b0, 5'h10, 32'h0, lo);
    chk("ctrl after init", 35'h11, {3'b0, lo});
    for (int it = 0; it < 80; it++) begin
      k = $urandom_range(34, 0);
      m = {3'($urandom), $urandom};
      m[29] = 1'b1;
      main_active <= 1'($urandom);
      normal_mode <= 1'($urandom);
      ext_pass <= 1'($urandom);
      bb <= 1'($urandom);
      act <= 1'($urandom);
      bus(1'b1, 5'h08, m[31:0], lo);
      bus(1'b1, 5'h0C, {29'h0, m[34:32]}, lo);
      p0 = pulses;
      e = '0;
      if (k == 29) begin
        bus(1'b1, 5'h10, 32'h100, lo);
        e[29] = 1'b1;
      end else if (k == 32) begin
        n = $urandom_range(17, 15);
        nclk <= 5'(n);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2 * n + 4) @(posedge clk);
        e[32] = main_active && n != 16;
      end else if (k > 30) begin
        f = sip_spi_frame_t'({1'b1, 6'($urandom)});
        frame <= f;
        @(posedge clk);
        frame <= '0;
        e = frame_exp(f, normal_mode, main_active);
      end else begin
        lv[k] <= 1'b1;
        repeat (2) @(posedge clk);
        if (k == 6) chk("supply off", 35'h0, {34'h0, can_supply_en});
        lv[k] <= 1'b0;
        e[k] = !((k == 3 || k == 5) && !ext_pass);
      end
      repeat (12) @(posedge clk);
      chk("irq", {34'h0, |(e & m)}, {34'h0, irq});
      chk("pulses", {27'h0, 8'(p0 + (|(e & m)))}, {27'h0, pulses});
      if (k == 29) chk("pulse len", 35'(2 * TICK), {27'h0, plen});
      bus(1'b0, 5'h14, 32'h0, lo);
      chk("state", {30'h0, 3'h4, act, bb}, {3'b0, lo});
      bus(1'b0, 5'h00, 32'h0, lo);
      bus(1'b0, 5'h04, 32'h0, hi);
      chk("status", e, {hi[2:0], lo});
      chk("irq cleared", 35'h0, {34'h0, irq});
    end
    final_report();
  end
endmodule // tb_sbc_interrupt_pulse_generator

`default_nettype wire
